// file: src/jdap_map.vh
// constants of the serial debug port: register map, commands, tap states
// assumes inclusion by the tap and top modules, checker and test bench
`ifndef JDAP_MAP_VH
`define JDAP_MAP_VH

// ----------------------------------------------------------------------
// cpu register offsets (byte addresses)
// ----------------------------------------------------------------------
`define JDAP_ADDR_CMD       32'hFFF00000
`define JDAP_ADDR_DATA_HI   32'hFFF00008
`define JDAP_ADDR_DATA_LO   32'hFFF0000A
`define JDAP_ADDR_INT       32'hFFF00014

// ----------------------------------------------------------------------
// reset values and fixed patterns
// ----------------------------------------------------------------------
`define JDAP_CMD_RST        16'hFFFF
`define JDAP_INT_RST        16'h0000
`define JDAP_CMD_LOW_BITS   8'hFF
`define JDAP_IR_CAPTURE     32'hFFFFFFFD
`define JDAP_IRQ_BIT        0
`define JDAP_TI_MSB         15
`define JDAP_TI_LSB         8
`define JDAP_IR_LEN         32

// ----------------------------------------------------------------------
// command codes (upper command byte)
// ----------------------------------------------------------------------
`define JDAP_CMD_EXTEST     8'h00
`define JDAP_CMD_SAMPLE     8'h04
`define JDAP_CMD_RSTNEG     4'h6
`define JDAP_CMD_RSTASR     4'h7
`define JDAP_CMD_INTR       3'h5
`define JDAP_CMD_BYPASS     8'hFF

// ----------------------------------------------------------------------
// tap controller states
// ----------------------------------------------------------------------
`define JDAP_TLR            4'hF
`define JDAP_RTI            4'hC
`define JDAP_SEL_DR         4'h7
`define JDAP_CAP_DR         4'h6
`define JDAP_SH_DR          4'h2
`define JDAP_EX1_DR         4'h1
`define JDAP_PAU_DR         4'h3
`define JDAP_EX2_DR         4'h0
`define JDAP_UPD_DR         4'h5
`define JDAP_SEL_IR         4'h4
`define JDAP_CAP_IR         4'hE
`define JDAP_SH_IR          4'hA
`define JDAP_EX1_IR         4'h9
`define JDAP_PAU_IR         4'hB
`define JDAP_EX2_IR         4'h8
`define JDAP_UPD_IR         4'hD

`endif

// file: src/jdap_sync.v
// three-stage synchroniser with agreement filter and edge pulses
// assumes inputs are asynchronous pins, clk is the system clock
`timescale 1ns/1ns
module jdap_sync #(
  parameter W   = 4,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  clk,
  rst,
  din,
  lvl,
  rise,
  fall
);
  input  wire         clk;
  input  wire         rst;
  input  wire [W-1:0] din;
  output wire [W-1:0] lvl;
  output wire [W-1:0] rise;
  output wire [W-1:0] fall;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_ff;
      reg s2_ff;
      reg s3_ff;
      reg lvl_ff;
      reg rise_ff;
      reg fall_ff;
      // a change counts only when stages two and three agree
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_ff   <= RST[i];
          s2_ff   <= RST[i];
          s3_ff   <= RST[i];
          lvl_ff  <= RST[i];
          rise_ff <= 1'b0;
          fall_ff <= 1'b0;
        end else begin
          s1_ff   <= din[i];
          s2_ff   <= s1_ff;
          s3_ff   <= s2_ff;
          rise_ff <= 1'b0;
          fall_ff <= 1'b0;
          if ((s2_ff == s3_ff) && (s3_ff != lvl_ff)) begin
            lvl_ff  <= s3_ff;
            rise_ff <= s3_ff;
            fall_ff <= ~s3_ff;
          end
        end
      end
      assign lvl[i]  = lvl_ff;
      assign rise[i] = rise_ff;
      assign fall[i] = fall_ff;
    end
  endgenerate
endmodule // jdap_sync

// file: src/jdap_tap.v
// test access port state machine, advanced on sampled test clock rises
// assumes tms is sampled in the same stage as the test clock edge
`timescale 1ns/1ns
`include "jdap_map.vh"
module jdap_tap (
  clk,
  rst,
  trst_lo,
  adv,
  tms,
  state
);
  input  wire       clk;
  input  wire       rst;
  input  wire       trst_lo;
  input  wire       adv;
  input  wire       tms;
  output wire [3:0] state;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;

  always @* begin
    case (state_ff)
      `JDAP_TLR:    nxt_state = tms ? `JDAP_TLR    : `JDAP_RTI;
      `JDAP_RTI:    nxt_state = tms ? `JDAP_SEL_DR : `JDAP_RTI;
      `JDAP_SEL_DR: nxt_state = tms ? `JDAP_SEL_IR : `JDAP_CAP_DR;
      `JDAP_CAP_DR: nxt_state = tms ? `JDAP_EX1_DR : `JDAP_SH_DR;
      `JDAP_SH_DR:  nxt_state = tms ? `JDAP_EX1_DR : `JDAP_SH_DR;
      `JDAP_EX1_DR: nxt_state = tms ? `JDAP_UPD_DR : `JDAP_PAU_DR;
      `JDAP_PAU_DR: nxt_state = tms ? `JDAP_EX2_DR : `JDAP_PAU_DR;
      `JDAP_EX2_DR: nxt_state = tms ? `JDAP_UPD_DR : `JDAP_SH_DR;
      `JDAP_UPD_DR: nxt_state = tms ? `JDAP_SEL_DR : `JDAP_RTI;
      `JDAP_SEL_IR: nxt_state = tms ? `JDAP_TLR    : `JDAP_CAP_IR;
      `JDAP_CAP_IR: nxt_state = tms ? `JDAP_EX1_IR : `JDAP_SH_IR;
      `JDAP_SH_IR:  nxt_state = tms ? `JDAP_EX1_IR : `JDAP_SH_IR;
      `JDAP_EX1_IR: nxt_state = tms ? `JDAP_UPD_IR : `JDAP_PAU_IR;
      `JDAP_PAU_IR: nxt_state = tms ? `JDAP_EX2_IR : `JDAP_PAU_IR;
      `JDAP_EX2_IR: nxt_state = tms ? `JDAP_UPD_IR : `JDAP_SH_IR;
      `JDAP_UPD_IR: nxt_state = tms ? `JDAP_SEL_DR : `JDAP_RTI;
      default:      nxt_state = `JDAP_TLR;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= `JDAP_TLR;
    end else if (trst_lo) begin
      state_ff <= `JDAP_TLR;
    end else if (adv) begin
      state_ff <= nxt_state;
    end
  end

  assign state = state_ff;
endmodule // jdap_tap

// file: src/jdap_top.v
// serial debug port: tap, command/bypass/scan/interrupt paths, cpu regs
// assumes pins tck/tms/tdi/trst_n asynchronous to mclk, tck << mclk
//
// Summary of operation
// - tap resets by trst or tms high
// - command, irq flag also reset by tap; tdo enable by trst; rest by chip reset, except bypass, scan shift and data regs
// - standard tap states, shift and update
// - one-bit bypass stage tdi to tdo
// - boundary scan chain shifted serially
// - command register loaded over serial path
// - tdi captured, tdo driven with test clock
// - tms steers interpretation of tdi
// - trst asynchronous, holds tap in reset
// - cpu sees command, data, interrupt regs only
// - serial command read returns fixed pattern
// - serial interrupt path read-only, lsb only
// - interrupt factor cleared by trst or reset state
// - cpu only clears flag; irq follows flag
// - bypass command selects bypass stage
// - command resets to bypass
`timescale 1ns/1ns
`include "jdap_map.vh"
module jdap_top #(
  parameter BSR_LEN = 8
) (
  mclk,
  sys_rst,
  tck,
  tms,
  tdi,
  trst_n,
  tdo,
  tdo_oe,
  cpu_sel,
  cpu_we,
  cpu_word,
  cpu_addr,
  cpu_wdata,
  cpu_rdata,
  debug_irq,
  dbg_rst_req,
  bsr_pin_in,
  bsr_pin_out
);
  input  wire               mclk;
  input  wire               sys_rst;
  input  wire               tck;
  input  wire               tms;
  input  wire               tdi;
  input  wire               trst_n;
  output wire               tdo;
  output wire               tdo_oe;
  input  wire               cpu_sel;
  input  wire               cpu_we;
  input  wire               cpu_word;
  input  wire [31:0]        cpu_addr;
  input  wire [31:0]        cpu_wdata;
  output wire [31:0]        cpu_rdata;
  output wire               debug_irq;
  output wire               dbg_rst_req;
  input  wire [BSR_LEN-1:0] bsr_pin_in;
  output wire [BSR_LEN-1:0] bsr_pin_out;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  wire [3:0] pin_lvl;
  wire [3:0] pin_rise;
  wire [3:0] pin_fall;

  jdap_sync #(
    .W   (4),
    .RST (4'h6)
  ) u_sync (
    .clk  (mclk),
    .rst  (sys_rst),
    .din  ({trst_n, tdi, tms, tck}),
    .lvl  (pin_lvl),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  wire tck_rise = pin_rise[0];
  wire tck_fall = pin_fall[0];
  wire tms_s    = pin_lvl[1];
  wire tdi_s    = pin_lvl[2];
  wire trst_lo  = ~pin_lvl[3];

  // --------------------------------------------------------------------
  // tap controller
  // --------------------------------------------------------------------
  wire [3:0] tap_st;

  jdap_tap u_tap (
    .clk     (mclk),
    .rst     (sys_rst),
    .trst_lo (trst_lo),
    .adv     (tck_rise),
    .tms     (tms_s),
    .state   (tap_st)
  );

  wire tap_rst = trst_lo | (tap_st == `JDAP_TLR);
  wire at_cir  = tck_rise & (tap_st == `JDAP_CAP_IR);
  wire at_sir  = tck_rise & (tap_st == `JDAP_SH_IR);
  wire at_uir  = tck_rise & (tap_st == `JDAP_UPD_IR);
  wire at_cdr  = tck_rise & (tap_st == `JDAP_CAP_DR);
  wire at_sdr  = tck_rise & (tap_st == `JDAP_SH_DR);
  wire at_udr  = tck_rise & (tap_st == `JDAP_UPD_DR);

  // --------------------------------------------------------------------
  // command register and decode
  // --------------------------------------------------------------------
  reg [15:0] cmd_ff;
  reg [31:0] ir_sh_ff;
  wire [7:0] ti = cmd_ff[`JDAP_TI_MSB:`JDAP_TI_LSB];
  wire [7:0] ir_new = ir_sh_ff[31:24];

  wire sel_byp  = (ti == `JDAP_CMD_BYPASS);
  wire sel_bsr  = (ti == `JDAP_CMD_EXTEST) | (ti == `JDAP_CMD_SAMPLE);
  wire sel_int  = (ti[7:5] == `JDAP_CMD_INTR);
  wire new_int  = (ir_new[7:5] == `JDAP_CMD_INTR);

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_ff   <= `JDAP_CMD_RST;
      ir_sh_ff <= `JDAP_IR_CAPTURE;
    end else if (tap_rst) begin
      cmd_ff   <= `JDAP_CMD_RST;
      ir_sh_ff <= `JDAP_IR_CAPTURE;
    end else if (at_cir) begin
      ir_sh_ff <= `JDAP_IR_CAPTURE;
    end else if (at_sir) begin
      ir_sh_ff <= {tdi_s, ir_sh_ff[31:1]};
    end else if (at_uir) begin
      cmd_ff <= {ir_new, `JDAP_CMD_LOW_BITS};
    end
  end

  // --------------------------------------------------------------------
  // data paths: bypass, boundary chain, interrupt factor
  // --------------------------------------------------------------------
  reg               byp_ff;
  reg [BSR_LEN-1:0] bsr_sh_ff;
  reg [BSR_LEN-1:0] bsr_out_ff;
  reg [31:0]        int_sh_ff;
  reg               irq_ff;

  // not reset: contents undefined like the bypass stage itself
  always @(posedge mclk) begin
    if (at_cdr & sel_byp) begin
      byp_ff <= 1'b0;
    end else if (at_sdr & sel_byp) begin
      byp_ff <= tdi_s;
    end
  end

  always @(posedge mclk) begin
    if (at_cdr & sel_bsr) begin
      bsr_sh_ff <= bsr_pin_in;
    end else if (at_sdr & sel_bsr) begin
      bsr_sh_ff <= {tdi_s, bsr_sh_ff[BSR_LEN-1:1]};
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      bsr_out_ff <= {BSR_LEN{1'b0}};
    end else if (at_udr & sel_bsr) begin
      bsr_out_ff <= bsr_sh_ff;
    end
  end

  // shifted bits never reach the flag
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      int_sh_ff <= 32'h00000000;
    end else if (at_cdr & sel_int) begin
      int_sh_ff <= {16'h0000, 15'h0000, irq_ff};
    end else if (at_sdr & sel_int) begin
      int_sh_ff <= {tdi_s, int_sh_ff[31:1]};
    end
  end

  // --------------------------------------------------------------------
  // serial output, changes on tck fall
  // --------------------------------------------------------------------
  reg  tdo_ff;
  reg  tdo_oe_ff;
  wire in_sir = (tap_st == `JDAP_SH_IR);
  wire in_sdr = (tap_st == `JDAP_SH_DR);
  reg  nxt_tdo;

  always @* begin
    if (in_sir) begin
      nxt_tdo = ir_sh_ff[0];
    end else if (sel_bsr) begin
      nxt_tdo = bsr_sh_ff[0];
    end else if (sel_int) begin
      nxt_tdo = int_sh_ff[0];
    end else begin
      nxt_tdo = byp_ff;
    end
  end

  // tdo updated on falling test clock
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tdo_ff    <= 1'b1;
      tdo_oe_ff <= 1'b0;
    end else if (trst_lo) begin
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= in_sir | in_sdr;
    end
  end

  // --------------------------------------------------------------------
  // interrupt flag and reset request
  // --------------------------------------------------------------------
  wire cpu_int_wr = cpu_sel & cpu_we & (cpu_addr == `JDAP_ADDR_INT);
  wire cpu_clr    = cpu_int_wr & ~cpu_wdata[`JDAP_IRQ_BIT];
  wire irq_set    = at_uir & new_int;
  reg  rst_req_ff;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else if (tap_rst) begin
      irq_ff <= 1'b0;
    end else if (irq_set) begin
      irq_ff <= 1'b1;
    end else if (cpu_clr) begin
      irq_ff <= 1'b0;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_req_ff <= 1'b0;
    end else if (at_uir & (ir_new[7:4] == `JDAP_CMD_RSTASR)) begin
      rst_req_ff <= 1'b1;
    end else if (at_uir & (ir_new[7:4] == `JDAP_CMD_RSTNEG)) begin
      rst_req_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // cpu register access
  // --------------------------------------------------------------------
  reg  [31:0] data_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] nxt_rdata;
  wire hit_hi = cpu_sel & (cpu_addr == `JDAP_ADDR_DATA_HI);
  wire hit_lo = cpu_sel & (cpu_addr == `JDAP_ADDR_DATA_LO);

  // word or half access, no reset
  always @(posedge mclk) begin
    if (cpu_we & hit_hi & cpu_word) begin
      data_ff <= cpu_wdata;
    end else if (cpu_we & hit_hi) begin
      data_ff[31:16] <= cpu_wdata[15:0];
    end else if (cpu_we & hit_lo) begin
      data_ff[15:0] <= cpu_wdata[15:0];
    end
  end

  always @* begin
    nxt_rdata = 32'h00000000;
    if (cpu_addr == `JDAP_ADDR_CMD) begin
      nxt_rdata = {16'h0000, cmd_ff};
    end else if (hit_hi & cpu_word) begin
      nxt_rdata = data_ff;
    end else if (hit_hi) begin
      nxt_rdata = {16'h0000, data_ff[31:16]};
    end else if (hit_lo) begin
      nxt_rdata = {16'h0000, data_ff[15:0]};
    end else if (cpu_addr == `JDAP_ADDR_INT) begin
      nxt_rdata = {16'h0000, 15'h0000, irq_ff};
    end
  end

  // registered read, one cycle after the select
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 32'h00000000;
    end else if (cpu_sel & ~cpu_we) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign tdo         = tdo_ff;
  assign tdo_oe      = tdo_oe_ff;
  assign cpu_rdata   = rdata_ff;
  assign debug_irq   = irq_ff;
  assign dbg_rst_req = rst_req_ff;
  assign bsr_pin_out = bsr_out_ff;
endmodule // jdap_top

// file: bench/jdap_top_checker.sv
// checker: timing relations at the debug port top pins
// assumes bind onto jdap_top, all checks in the mclk domain
`timescale 1ns/1ns
`include "jdap_map.vh"
module jdap_top_checker (
  input wire        mclk,
  input wire        sys_rst,
  input wire        tck,
  input wire        tms,
  input wire        trst_n,
  input wire        tdo,
  input wire        tdo_oe,
  input wire        cpu_sel,
  input wire        cpu_we,
  input wire [31:0] cpu_addr,
  input wire [31:0] cpu_wdata,
  input wire [31:0] cpu_rdata,
  input wire        debug_irq
);
  logic [3:0] quiet_ff;
  logic [3:0] trlo_ff;
  wire        rd_hit;
  wire        clr_w;
  wire        mapped;
  assign rd_hit = cpu_sel && !cpu_we;
  assign clr_w = cpu_sel && cpu_we && cpu_addr == `JDAP_ADDR_INT
                 && !cpu_wdata[0];
  assign mapped = cpu_addr == `JDAP_ADDR_CMD
                  || cpu_addr == `JDAP_ADDR_DATA_HI
                  || cpu_addr == `JDAP_ADDR_DATA_LO
                  || cpu_addr == `JDAP_ADDR_INT;
  // saturating counts; long enough to cover synchroniser latency
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_ff <= 4'h0;
      trlo_ff <= 4'h0;
    end else begin
      quiet_ff <= (!trst_n || tms) ? 4'h0 :
                  quiet_ff + {3'h0, quiet_ff != 4'hF};
      trlo_ff <= trst_n ? 4'h0 : trlo_ff + {3'h0, trlo_ff != 4'hF};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence rd_s(a);
    rd_hit && cpu_addr == a;
  endsequence
  reset_out_a:
    assert property ($fell(sys_rst) |-> tdo && !tdo_oe && !debug_irq)
    else $error("outputs wrong after chip reset");
  trst_clear_a:
    assert property (trlo_ff >= 4'h6 |-> !tdo_oe && !debug_irq)
    else $error("tap reset pin not holding");
  irq_hold_a:
    assert property (debug_irq && !clr_w && quiet_ff >= 4'h8 |=> debug_irq)
    else $error("irq dropped without clear");
  rd_int_a:
    assert property (rd_s(`JDAP_ADDR_INT) |=>
      cpu_rdata == {31'h0, $past(debug_irq)})
    else $error("interrupt factor read wrong");
  rd_cmd_a:
    assert property (rd_s(`JDAP_ADDR_CMD) |=>
      cpu_rdata[7:0] == 8'hFF && cpu_rdata[31:16] == 16'h0)
    else $error("command read wrong");
  cmd_bypass_a:
    assert property (trlo_ff >= 4'h6 ##0 rd_s(`JDAP_ADDR_CMD) |=>
      cpu_rdata == 32'h0000FFFF)
    else $error("command not bypass in reset");
  unmapped_a:
    assert property (rd_hit && !mapped |=> cpu_rdata == 32'h0)
    else $error("unmapped read not zero");
  tdo_edge_a:
    assert property ($changed(tdo) |-> !tck && !$past(tck))
    else $error("tdo moved while tck high");
  oe_edge_a:
    assert property ($changed(tdo_oe) |-> !tck)
    else $error("tdo enable moved while tck high");
endmodule // jdap_top_checker
bind jdap_top jdap_top_checker jdap_top_checker_inst (
  .mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
  .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .cpu_sel(cpu_sel),
  .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .cpu_rdata(cpu_rdata), .debug_irq(debug_irq)
);

// file: bench/jdap_probe.sv
// behavioural probe driving the test port pins
// assumes tck idles low outside frames, period 160 ns
`timescale 1ns/1ns
module jdap_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input  wire  tdo
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    trst_n = 1'h0;
  end
  task set_trst(input logic v);
    trst_n = v;
  endtask
  task bit_io(input logic m, input logic d, output logic q);
    begin
      tms = m;
      tdi = d;
      #80 tck = 1'h1;
      q = tdo;
      #80 tck = 1'h0;
    end
  endtask
  task tap_reset;
    logic q;
    begin
      repeat (5) bit_io(1'h1, 1'h1, q);
      bit_io(1'h0, 1'h1, q);
    end
  endtask
  task scan(input logic ir, input int n, input logic [31:0] din,
            output logic [31:0] dout);
    logic q;
    begin
      dout = 32'h0;
      bit_io(1'h1, 1'h1, q);
      if (ir)
        bit_io(1'h1, 1'h1, q);
      bit_io(1'h0, 1'h1, q);
      bit_io(1'h0, 1'h1, q);
      for (int i = 0; i < n; i++) begin
        bit_io(i == n - 1, din[i], q);
        dout[i] = q;
      end
      // idle tdi stays high, as the pin pull-up would leave it
      bit_io(1'h1, 1'h1, q);
      bit_io(1'h0, 1'h1, q);
    end
  endtask
endmodule // jdap_probe

// file: bench/test_jdap_top.sv
// self-checking bench: cpu register calls and probe scans
// assumes jdap_top with BSR_LEN 8, probe model on the pins
`timescale 1ns/1ns
`include "jdap_map.vh"
module test_jdap_top;
  logic        mclk;
  logic        sys_rst;
  logic        cpu_sel;
  logic        cpu_we;
  logic        cpu_word;
  logic [31:0] cpu_addr;
  logic [31:0] cpu_wdata;
  logic [31:0] rd;
  logic [31:0] so;
  logic [7:0]  codes [6] = '{8'h00, 8'h04, 8'h70, 8'hA0, 8'h60, 8'hFF};
  wire  [31:0] cpu_rdata;
  wire  [7:0]  bsr_pin_out;
  wire         tck, tms, tdi, trst_n, tdo, tdo_oe, debug_irq, dbg_rst_req;
  // no pull-up on tdo: a released pin shows the inverse, so a lost enable
  // corrupts every scan the probe reads
  wire         tdo_pin = tdo_oe ? tdo : ~tdo;
  int          num_errors;
  int          checked;
  jdap_top jdap_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .cpu_sel(cpu_sel),
    .cpu_we(cpu_we), .cpu_word(cpu_word), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .debug_irq(debug_irq),
    .dbg_rst_req(dbg_rst_req), .bsr_pin_in(8'h3C),
    .bsr_pin_out(bsr_pin_out)
  );
  jdap_probe jdap_probe_inst (
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_pin)
  );
  task give_verdict;
    begin
      if (num_errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checked++;
      if (seen !== exp) begin
        num_errors++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cpu_acc(input logic we, input logic wd, input logic [31:0] a,
               input logic [31:0] d);
    begin
      @(posedge mclk) #1;
      cpu_sel = 1'h1;
      cpu_we = we;
      cpu_word = wd;
      cpu_addr = a;
      cpu_wdata = d;
      @(posedge mclk) #1;
      cpu_sel = 1'h0;
      rd = cpu_rdata;
    end
  endtask
  // half-word reads are judged on the low half only
  task rchk(input logic [31:0] a, input logic wd, input logic [31:0] e);
    begin
      cpu_acc(1'h0, wd, a, 32'h0);
      check(wd ? rd : {16'h0, rd[15:0]}, e);
    end
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #500000;
    num_errors++;
    give_verdict;
  end
  initial begin
    sys_rst = 1'h1;
    cpu_sel = 1'h0;
    cpu_we = 1'h0;
    cpu_word = 1'h0;
    cpu_addr = 32'h0;
    cpu_wdata = 32'h0;
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'h0;
    repeat (8) @(posedge mclk);
    rchk(`JDAP_ADDR_CMD, 1'h0, 32'hFFFF);
    rchk(`JDAP_ADDR_INT, 1'h0, 32'h0);
    rchk(32'hFFF00004, 1'h1, 32'h0);
    cpu_acc(1'h1, 1'h0, `JDAP_ADDR_CMD, 32'h1234);
    rchk(`JDAP_ADDR_CMD, 1'h0, 32'hFFFF);
    cpu_acc(1'h1, 1'h1, `JDAP_ADDR_DATA_HI, 32'h12345678);
    cpu_acc(1'h1, 1'h0, `JDAP_ADDR_DATA_LO, 32'hBEEF);
    rchk(`JDAP_ADDR_DATA_HI, 1'h1, 32'h1234BEEF);
    rchk(`JDAP_ADDR_DATA_HI, 1'h0, 32'h1234);
    rchk(`JDAP_ADDR_DATA_LO, 1'h0, 32'hBEEF);
    jdap_probe_inst.set_trst(1'h1);
    jdap_probe_inst.tap_reset;
    jdap_probe_inst.scan(1'h1, 32, 32'hFFFFFFFF, so);
    check(so, `JDAP_IR_CAPTURE);
    jdap_probe_inst.scan(1'h0, 8, 32'hA5, so);
    check({25'h0, so[7:1]}, 32'h25);
    jdap_probe_inst.scan(1'h1, 32, 32'hA0FFFFFF, so);
    check({31'h0, debug_irq}, 32'h1);
    rchk(`JDAP_ADDR_CMD, 1'h0, 32'hA0FF);
    jdap_probe_inst.scan(1'h0, 32, 32'hFFFFFFFF, so);
    check(so, 32'h1);
    rchk(`JDAP_ADDR_INT, 1'h0, 32'h1);
    cpu_acc(1'h1, 1'h0, `JDAP_ADDR_INT, 32'h1);
    rchk(`JDAP_ADDR_INT, 1'h0, 32'h1);
    cpu_acc(1'h1, 1'h0, `JDAP_ADDR_INT, 32'h0);
    rchk(`JDAP_ADDR_INT, 1'h0, 32'h0);
    jdap_probe_inst.scan(1'h1, 32, 32'hA0FFFFFF, so);
    jdap_probe_inst.tap_reset;
    check({31'h0, debug_irq}, 32'h0);
    rchk(`JDAP_ADDR_CMD, 1'h0, 32'hFFFF);
    jdap_probe_inst.scan(1'h1, 32, 32'hA0FFFFFF, so);
    jdap_probe_inst.set_trst(1'h0);
    #200;
    check({31'h0, debug_irq}, 32'h0);
    rchk(`JDAP_ADDR_CMD, 1'h0, 32'hFFFF);
    rchk(`JDAP_ADDR_DATA_HI, 1'h1, 32'h1234BEEF);
    jdap_probe_inst.set_trst(1'h1);
    jdap_probe_inst.tap_reset;
    jdap_probe_inst.scan(1'h1, 32, 32'h04FFFFFF, so);
    jdap_probe_inst.scan(1'h0, 8, 32'h5A, so);
    check(so, 32'h3C);
    check({24'h0, bsr_pin_out}, 32'h5A);
    foreach (codes[i]) begin
      jdap_probe_inst.scan(1'h1, 32, {codes[i], 24'hFFFFFF}, so);
      rchk(`JDAP_ADDR_CMD, 1'h0, {16'h0, codes[i], 8'hFF});
      check({31'h0, dbg_rst_req}, {31'h0, i == 2 || i == 3});
    end
    jdap_probe_inst.scan(1'h1, 32, 32'h70FFFFFF, so);
    check({31'h0, dbg_rst_req}, 32'h1);
    @(posedge mclk) #1;
    sys_rst = 1'h1;
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'h0;
    check({31'h0, dbg_rst_req}, 32'h0);
    rchk(`JDAP_ADDR_CMD, 1'h0, 32'hFFFF);
    give_verdict;
  end
endmodule // test_jdap_top
